//--- common/exec_pkg.sv
// Shared types and constants for the subtract, swap and skip execution unit
package exec_pkg;

    // Data path geometry
    localparam int DATA_WIDTH    = 8;
    localparam int ADDR_WIDTH    = 8;
    localparam int MEM_DEPTH     = 208;
    localparam int NIBBLE_WIDTH  = 4;
    localparam int LOW_NIB_MSB   = 3;
    localparam int HIGH_NIB_LSB  = 4;
    localparam int HIGH_NIB_MSB  = 7;

    // Reset values
    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;

    // Carry levels: carry set means no borrow
    localparam logic CARRY_BORROW    = 1'b0;
    localparam logic CARRY_NO_BORROW = 1'b1;

    // Cycle counts: one execute cycle, one extra dummy cycle on a taken skip
    localparam int EXEC_CYCLES = 1;
    localparam int SKIP_EXTRA  = 1;

    // Operations accepted on the request port
    typedef enum logic [2:0] {
        OP_SUB,     // accumulator <- accumulator - memory
        OP_SUBMEM,  // subtract_to_memory: memory <- accumulator - memory
        OP_SUBIMM,  // accumulator <- accumulator - immediate
        OP_SWAP,    // memory nibbles exchanged in place
        OP_SWAPACC, // nibble_exchange_to_accumulator
        OP_SKIPZ,   // skip_if_zero
        OP_LOAD     // memory <- immediate, used to preload operands
    } op_type;

    // One request
    typedef struct packed {
        op_type                 op;
        logic [ADDR_WIDTH-1:0]  addr;
        logic [DATA_WIDTH-1:0]  imm;
    } request_type;

    // Status flags touched by the subtract group
    typedef struct packed {
        logic overflowFlag;
        logic zero;
        logic auxiliaryCarryFlag;
        logic carry;
    } flags_type;

    localparam flags_type FLAGS_RESET = '0;

endpackage

//--- hw/data_memory.sv
// Small byte-wide data memory with a registered read port
module data_memory
    import exec_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH,
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW    = ADDR_WIDTH
)(
    input  wire logic             core_clk,
    input  wire logic             readEn,
    input  wire logic [AW-1:0]    readAddr,
    output logic      [WIDTH-1:0] readData,
    input  wire logic             writeEn,
    input  wire logic [AW-1:0]    writeAddr,
    input  wire logic [WIDTH-1:0] writeData
);

    logic [WIDTH-1:0] store [DEPTH];

    // Writes outside the array are dropped rather than aliased
    always_ff @(posedge core_clk)
    begin
        if (writeEn && (int'(writeAddr) < DEPTH))
        begin
            store[writeAddr] <= writeData;
        end
    end

    // Read data comes from a register; unmapped addresses read zero
    always_ff @(posedge core_clk)
    begin
        if (readEn)
        begin
            if (int'(readAddr) < DEPTH)
            begin
                readData <= store[readAddr];
            end
            else
            begin
                readData <= '0;
            end
        end
    end

endmodule // data_memory

//--- hw/subtract_swap_skip_ops.sv
// Execution unit for the subtract, nibble swap and skip-if-zero instructions
// What this block does
// - Memory subtract: accumulator minus byte, into accumulator
// - Carry cleared on borrow, else set
// - Subtract_to_memory writes difference back, accumulator kept
// - Immediate subtract from accumulator, carry by borrow
// - In-place swap exchanges nibbles, flags untouched
// - Swap to accumulator loads exchanged nibbles
// - Swap to accumulator leaves memory unchanged
// - Skip next instruction when byte is zero
// - Taken skip adds one dummy cycle
module subtract_swap_skip_ops
    import exec_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
)(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  request_type      request,
    output logic             busy,
    output logic             done,
    output logic             skipNext,
    output logic [7:0]       accumulator,
    output flags_type        flags,
    output logic [7:0]       lastRead
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DUMMY
    } state_type;

    state_type          stateQ;
    request_type        reqQ;
    logic               accept;
    logic [7:0]         memRdata;
    logic [7:0]         operandB;
    logic [8:0]         fullDiff;
    logic [4:0]         nibbleDiff;
    logic [7:0]         diffW;
    logic [7:0]         swapW;
    flags_type          subFlags;
    logic               isSub;
    logic               execNow;
    logic               memWe;
    logic [7:0]         memWdata;

    // Requests are only taken while idle; a start during busy is ignored
    assign accept  = start && (stateQ == ST_IDLE);
    assign execNow = (stateQ == ST_EXEC);

    // Memory read is issued with the request so data is ready in execute
    data_memory #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (DEPTH),
        .AW    (ADDR_WIDTH)
    ) u_mem (
        .core_clk  (core_clk),
        .readEn    (accept),
        .readAddr  (request.addr),
        .readData  (memRdata),
        .writeEn   (memWe),
        .writeAddr (reqQ.addr),
        .writeData (memWdata)
    );

    // Subtraction as add of inverted operand plus one: carry out means no borrow
    // immediate operand select
    assign operandB   = (reqQ.op == OP_SUBIMM) ? reqQ.imm : memRdata;
    assign fullDiff   = {1'b0, accumulator} + {1'b0, ~operandB} + 9'h001;
    assign nibbleDiff = {1'b0, accumulator[LOW_NIB_MSB:0]}
                      + {1'b0, ~operandB[LOW_NIB_MSB:0]} + 5'h01;
    assign diffW      = fullDiff[7:0];
    assign swapW      = {memRdata[LOW_NIB_MSB:0], memRdata[HIGH_NIB_MSB:HIGH_NIB_LSB]};
    assign isSub      = (reqQ.op == OP_SUB) || (reqQ.op == OP_SUBMEM)
                      || (reqQ.op == OP_SUBIMM);

    // Flag values for any subtract variant
    always_comb
    begin
        subFlags.carry              = fullDiff[8] ? CARRY_NO_BORROW : CARRY_BORROW;
        subFlags.auxiliaryCarryFlag = nibbleDiff[NIBBLE_WIDTH];
        subFlags.zero               = (diffW == ZERO_BYTE);
        subFlags.overflowFlag       = (accumulator[7] != operandB[7])
                                    && (diffW[7] != accumulator[7]);
    end

    // Memory write port: subtract_to_memory, in-place swap and preload only
    always_comb
    begin
        memWe    = 1'b0;
        memWdata = diffW;
        if (execNow)
        begin
            case (reqQ.op)
                OP_SUBMEM:
                begin
                    memWe    = 1'b1;
                    memWdata = diffW;
                end
                OP_SWAP:
                begin
                    memWe    = 1'b1;
                    memWdata = swapW;
                end
                OP_LOAD:
                begin
                    memWe    = 1'b1;
                    memWdata = reqQ.imm;
                end
                // no write on swap to accumulator
                default:
                begin
                    memWe    = 1'b0;
                    memWdata = diffW;
                end
            endcase
        end
    end

    // Sequencer: idle, one execute cycle, optional dummy cycle on a taken skip
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateQ <= ST_IDLE;
        end
        else
        begin
            case (stateQ)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        stateQ <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    if ((reqQ.op == OP_SKIPZ) && (memRdata == ZERO_BYTE))
                    begin
                        stateQ <= ST_DUMMY;
                    end
                    else
                    begin
                        stateQ <= ST_IDLE;
                    end
                end
                default:
                begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    // Request capture
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reqQ <= '{op: OP_SUB, addr: '0, imm: '0};
        end
        else if (accept)
        begin
            reqQ <= request;
        end
    end

    // Accumulator update
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            accumulator <= ACC_RESET;
        end
        else if (execNow)
        begin
            if ((reqQ.op == OP_SUB) || (reqQ.op == OP_SUBIMM))
            begin
                accumulator <= diffW;
            end
            else if (reqQ.op == OP_SWAPACC)
            begin
                accumulator <= swapW;
            end
        end
    end

    // Flags change only on subtract; swaps and skips leave them alone
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags <= FLAGS_RESET;
        end
        else if (execNow && isSub)
        begin
            flags <= subFlags;
        end
    end

    // Handshake outputs: done ends every request, skipNext marks a taken skip
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy     <= 1'b0;
            done     <= 1'b0;
            skipNext <= 1'b0;
            lastRead <= ZERO_BYTE;
        end
        else
        begin
            done     <= 1'b0;
            skipNext <= 1'b0;
            if (accept)
            begin
                busy <= 1'b1;
            end
            else if (execNow)
            begin
                lastRead <= memRdata;
                if ((reqQ.op == OP_SKIPZ) && (memRdata == ZERO_BYTE))
                begin
                    busy     <= 1'b1;
                    skipNext <= 1'b1;
                end
                else
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
            else if (stateQ == ST_DUMMY)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end

    // Checks on the execute results

    property p_sub_acc;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SUB)
            |=> (accumulator == ($past(accumulator) - $past(memRdata))) && done;
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("memory subtract result wrong");

    property p_carry;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && isSub) |=> (flags.carry == ($past(accumulator) >= $past(operandB)));
    endproperty
    a_carry: assert property (p_carry) else $error("carry does not follow borrow");

    property p_submem;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SUBMEM)
            |-> memWe && (memWdata == (accumulator - memRdata)) ##1 $stable(accumulator);
    endproperty
    a_submem: assert property (p_submem) else $error("subtract to memory wrong");

    property p_subimm;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SUBIMM)
            |=> accumulator == $past(accumulator) - $past(reqQ.imm);
    endproperty
    a_subimm: assert property (p_subimm) else $error("immediate subtract wrong");

    property p_swap;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SWAP)
            |-> memWe && (memWdata[3:0] == memRdata[7:4])
                && (memWdata[7:4] == memRdata[3:0]) ##1 $stable(flags);
    endproperty
    a_swap: assert property (p_swap) else $error("in-place swap wrong");

    property p_swapacc;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SWAPACC)
            |=> (accumulator == {$past(memRdata[3:0]), $past(memRdata[7:4])})
                && $stable(flags);
    endproperty
    a_swapacc: assert property (p_swapacc) else $error("swap to accumulator wrong");

    property p_swapacc_nowrite;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SWAPACC) |-> !memWe;
    endproperty
    a_swapacc_nowrite: assert property (p_swapacc_nowrite) else $error("memory written on swap");

    property p_skip;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SKIPZ) |=> (skipNext == ($past(memRdata) == 8'h00));
    endproperty
    a_skip: assert property (p_skip) else $error("skip decision wrong");

    property p_skip_dummy;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && reqQ.op == OP_SKIPZ && memRdata == 8'h00)
            |=> busy && !done && (stateQ == ST_DUMMY) ##1 done && !busy;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip dummy cycle wrong");

    property p_zero;
        @(posedge core_clk) disable iff (!reset_n)
        (execNow && isSub) |=> (flags.zero == ($past(accumulator) == $past(operandB)));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule // subtract_swap_skip_ops

//--- test/subtract_swap_skip_ops_tb.sv
// Self-checking testbench for the subtract, nibble swap and skip-if-zero unit
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end

module subtract_swap_skip_ops_tb
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DLY = 1;

    logic        core_clk;
    logic        reset_n;
    logic        start;
    request_type request;
    logic        busy;
    logic        done;
    logic        skipNext;
    logic [7:0]  accumulator;
    flags_type   flags;
    logic [7:0]  lastRead;
    int          errors;
    int          checked;
    int          cyc;
    int          bz;
    logic        sk;

    subtract_swap_skip_ops #(
        .DEPTH (MEM_DEPTH)
    ) DUT (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .start       (start),
        .request     (request),
        .busy        (busy),
        .done        (done),
        .skipNext    (skipNext),
        .accumulator (accumulator),
        .flags       (flags),
        .lastRead    (lastRead)
    );

    // 25 MHz core clock
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // Reference flags of a minus b; carry set means no borrow
    function automatic flags_type subFlags(input logic [7:0] a, input logic [7:0] b);
        flags_type  f;
        logic [7:0] d;
        d = a - b;
        f.overflowFlag       = (a[7] != b[7]) && (d[7] != a[7]);
        f.zero               = (d == 8'h00);
        f.auxiliaryCarryFlag = (a[3:0] >= b[3:0]);
        f.carry              = (a >= b);
        return f;
    endfunction

    // One request; counts cycles to done so a taken skip shows its dummy cycle
    task automatic run(input op_type o, input logic [7:0] a, input logic [7:0] i);
        @(posedge core_clk);
        #DLY;
        start   = 1'b1;
        request = '{o, a, i};
        @(posedge core_clk);
        #DLY;
        start = 1'b0;
        cyc   = 0;
        bz    = 0;
        sk    = 1'b0;
        while (done !== 1'b1 && cyc < 10)
        begin
            if (skipNext === 1'b1)
                sk = 1'b1;
            if (busy === 1'b1)
                bz++;
            @(posedge core_clk);
            #DLY;
            cyc++;
        end
    endtask

    // Accumulator is set through the swap path, so no hidden back door is needed
    task automatic setAcc(input logic [7:0] v);
        run(OP_LOAD, 8'h10, {v[3:0], v[7:4]});
        run(OP_SWAPACC, 8'h10, 8'h00);
        `CHK(accumulator, v)
    endtask

    // Borrow, nibble borrow, zero and signed overflow corners on all three variants
    task automatic test_subtract();
        logic [15:0] pairs [5];
        logic [7:0]  a;
        logic [7:0]  m;
        logic [7:0]  d;
        flags_type   f;
        pairs = '{16'h5031, 16'h3050, 16'h4242, 16'h8001, 16'h7FFF};
        foreach (pairs[k])
        begin
            a = pairs[k][15:8];
            m = pairs[k][7:0];
            d = a - m;
            f = subFlags(a, m);
            setAcc(a);
            run(OP_LOAD, 8'h20, m);
            run(OP_SUB, 8'h20, 8'h00);
            `CHK(accumulator, d)
            `CHK(flags.carry, (a >= m) ? CARRY_NO_BORROW : CARRY_BORROW)
            `CHK(flags.zero, (d == 8'h00))
            `CHK(flags, f)
            setAcc(a);
            run(OP_SUBIMM, 8'h00, m);
            `CHK(accumulator, d)
            `CHK(flags, f)
            setAcc(a);
            run(OP_SUBMEM, 8'h20, 8'h00);
            `CHK(accumulator, a)
            `CHK(flags, f)
            run(OP_SKIPZ, 8'h20, 8'h00);
            `CHK(lastRead, d)
        end
        $display("test subtract finished");
    endtask

    // Swaps must leave flags exactly as the preceding subtract set them
    task automatic test_swap();
        flags_type f0;
        f0 = '{1'b0, 1'b1, 1'b1, 1'b1};
        setAcc(8'h3C);
        run(OP_SUBIMM, 8'h00, 8'h3C);
        `CHK(flags, f0)
        run(OP_LOAD, 8'h30, 8'hA5);
        run(OP_SWAP, 8'h30, 8'h00);
        `CHK(flags, f0)
        `CHK(accumulator, 8'h00)
        run(OP_SKIPZ, 8'h30, 8'h00);
        `CHK(lastRead, 8'h5A)
        run(OP_SWAPACC, 8'h30, 8'h00);
        `CHK(accumulator, 8'hA5)
        `CHK(flags, f0)
        run(OP_SKIPZ, 8'h30, 8'h00);
        `CHK(lastRead, 8'h5A)
        $display("test swap finished");
    endtask

    // Zero byte skips with one dummy cycle; nonzero high bit must not skip
    task automatic test_skip();
        run(OP_LOAD, 8'h40, 8'h00);
        run(OP_SKIPZ, 8'h40, 8'h00);
        `CHK(sk, 1'b1)
        `CHK(cyc, EXEC_CYCLES + SKIP_EXTRA)
        `CHK(bz, EXEC_CYCLES + SKIP_EXTRA)
        `CHK(busy, 1'b0)
        run(OP_LOAD, 8'h40, 8'h80);
        run(OP_SKIPZ, 8'h40, 8'h00);
        `CHK(sk, 1'b0)
        `CHK(cyc, EXEC_CYCLES)
        `CHK(bz, EXEC_CYCLES)
        `CHK(lastRead, 8'h80)
        $display("test skip finished");
    endtask

    // Verdict in one place for both normal end and watchdog
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        errors  = 0;
        checked = 0;
        start   = 1'b0;
        request = '0;
        reset_n = 1'b0;
        repeat (20) @(posedge core_clk);
        #DLY;
        reset_n = 1'b1;
        `CHK(accumulator, ACC_RESET)
        `CHK(flags, FLAGS_RESET)
        `CHK(busy, 1'b0)
        test_subtract();
        test_swap();
        test_skip();
        final_report();
    end

    // Whole run needs well under a thousand cycles; this cuts a hang short
    initial
    begin
        repeat (5000) @(posedge core_clk);
        errors++;
        final_report();
    end

endmodule // subtract_swap_skip_ops_tb
